// ---- include/io_line_pkg.sv ----
// Purpose: Shared constants for the I/O line control block.
// Assumes: APB with a 12-bit byte address and 32-bit data.
// Notes: Every register takes one aligned word.
package io_line_pkg;

   localparam int          LINES                = 32;
   localparam int          ADDR_W               = 12;

   localparam logic [11:0] LINE_OWNER_EN_OFF    = 12'h000;
   localparam logic [11:0] LINE_OWNER_DIS_OFF   = 12'h004;
   localparam logic [11:0] LINE_OWNER_STAT_OFF  = 12'h008;
   localparam logic [11:0] OUT_EN_SET_OFF       = 12'h010;
   localparam logic [11:0] OUT_EN_CLR_OFF       = 12'h014;
   localparam logic [11:0] OUT_EN_STAT_OFF      = 12'h018;
   localparam logic [11:0] FILT_EN_OFF          = 12'h020;
   localparam logic [11:0] FILT_DIS_OFF         = 12'h024;
   localparam logic [11:0] FILT_STAT_OFF        = 12'h028;
   localparam logic [11:0] DRIVE_SET_OFF        = 12'h030;
   localparam logic [11:0] DRIVE_CLR_OFF        = 12'h034;
   localparam logic [11:0] DRIVE_STAT_OFF       = 12'h038;
   localparam logic [11:0] PAD_STAT_OFF         = 12'h03c;
   localparam logic [11:0] DIRECT_WR_EN_OFF     = 12'h0a0;
   localparam logic [11:0] DIRECT_WR_DIS_OFF    = 12'h0a4;
   localparam logic [11:0] DIRECT_WR_STAT_OFF   = 12'h0a8;
   localparam logic [11:0] WRITE_PROTECT_OFF    = 12'h0e4;

   localparam int          WRITE_PROTECT_BIT    = 0;

   localparam logic [31:0] LINE_OWNER_RST       = 32'hffffffff;
   localparam logic [31:0] OUT_EN_RST           = 32'h00000000;
   localparam logic [31:0] FILT_RST             = 32'h00000000;
   localparam logic [31:0] DRIVE_RST            = 32'h00000000;
   localparam logic [31:0] DIRECT_WR_RST        = 32'h00000000;
   localparam logic [31:0] PAD_RST              = 32'h00000000;
   localparam logic        WRITE_PROTECT_RST    = 1'b0;

endpackage

// ---- core/setclr_bits.sv ----
// Purpose: One 32-bit bank of per-line bits with set, clear and masked load.
// Assumes: Masks are single-cycle strobes from the register decoder.
// Notes: A set wins over a clear, and both win over a load.
`timescale 1ns/1ns
module setclr_bits
#(
   parameter logic [31:0] RESET_VAL = 32'h00000000
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [31:0] set_mask,
   input  wire logic [31:0] clr_mask,
   input  wire logic [31:0] load_mask,
   input  wire logic [31:0] load_data,
   output logic      [31:0] bits_q
);

   logic [31:0] bits_r;
   logic [31:0] bits_nxt;

   assign bits_nxt = ((((bits_r & ~load_mask) | (load_data & load_mask)) & ~clr_mask) | set_mask);
   assign bits_q   = bits_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         bits_r <= RESET_VAL;
      else
         bits_r <= bits_nxt;
   end

endmodule

// ---- core/glitch_filter.sv ----
// Purpose: Per-line input glitch filter on the 32 pad inputs.
// Assumes: Pad inputs are synchronous to sys_clk.
// Notes: A level passes only after two equal samples in a row.
`timescale 1ns/1ns
module glitch_filter
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [31:0] raw_in,
   output logic      [31:0] clean_q
);

   logic [31:0] prev_r;
   logic [31:0] clean_r;
   logic [31:0] clean_nxt;

   assign clean_nxt = (raw_in & prev_r) | (clean_r & (raw_in | prev_r));
   assign clean_q   = clean_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         prev_r  <= 32'h00000000;
         clean_r <= 32'h00000000;
      end
      else
      begin
         prev_r  <= raw_in;
         clean_r <= clean_nxt;
      end
   end

endmodule

// ---- core/pin_io_line_control.sv ----
// Purpose: Per-line ownership, direction, filter and data control of 32 I/O lines.
// Assumes: APB slave, no wait states (pready high in the first access cycle); pads synchronous to sys_clk.
// Notes: Writes to unmapped offsets answer with pslverr; read-only offsets ignore writes.
`timescale 1ns/1ns
module pin_io_line_control
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pad_sample_enable,
   input  wire logic [31:0] pad_in,
   output logic      [31:0] pad_out,
   output logic      [31:0] pad_oe,
   input  wire logic [31:0] periph_out,
   input  wire logic [31:0] periph_oe,
   output logic      [31:0] periph_in
);

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic [31:0] strobe(input logic fire, input logic [31:0] data);
      strobe = fire ? data : 32'h00000000;
   endfunction

   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic        wp_r;
   logic [31:0] pad_level_r;
   logic [31:0] pad_out_r;
   logic [31:0] pad_oe_r;
   logic [31:0] periph_in_r;

   logic [31:0] owner_q;
   logic [31:0] oe_q;
   logic [31:0] filt_q;
   logic [31:0] drive_q;
   logic [31:0] dw_q;
   logic [31:0] clean_q;

   wire         setup_ph = psel & ~penable;
   wire         wr_fire  = psel & penable & pready_r & pwrite;

   wire         h_own_en  = hit(paddr, io_line_pkg::LINE_OWNER_EN_OFF);
   wire         h_own_dis = hit(paddr, io_line_pkg::LINE_OWNER_DIS_OFF);
   wire         h_own_st  = hit(paddr, io_line_pkg::LINE_OWNER_STAT_OFF);
   wire         h_oe_set  = hit(paddr, io_line_pkg::OUT_EN_SET_OFF);
   wire         h_oe_clr  = hit(paddr, io_line_pkg::OUT_EN_CLR_OFF);
   wire         h_oe_st   = hit(paddr, io_line_pkg::OUT_EN_STAT_OFF);
   wire         h_f_en    = hit(paddr, io_line_pkg::FILT_EN_OFF);
   wire         h_f_dis   = hit(paddr, io_line_pkg::FILT_DIS_OFF);
   wire         h_f_st    = hit(paddr, io_line_pkg::FILT_STAT_OFF);
   wire         h_d_set   = hit(paddr, io_line_pkg::DRIVE_SET_OFF);
   wire         h_d_clr   = hit(paddr, io_line_pkg::DRIVE_CLR_OFF);
   wire         h_d_st    = hit(paddr, io_line_pkg::DRIVE_STAT_OFF);
   wire         h_pad_st  = hit(paddr, io_line_pkg::PAD_STAT_OFF);
   wire         h_dw_en   = hit(paddr, io_line_pkg::DIRECT_WR_EN_OFF);
   wire         h_dw_dis  = hit(paddr, io_line_pkg::DIRECT_WR_DIS_OFF);
   wire         h_dw_st   = hit(paddr, io_line_pkg::DIRECT_WR_STAT_OFF);
   wire         h_wp      = hit(paddr, io_line_pkg::WRITE_PROTECT_OFF);

   wire         mapped = h_own_en | h_own_dis | h_own_st | h_oe_set | h_oe_clr | h_oe_st | h_f_en | h_f_dis
                       | h_f_st | h_d_set | h_d_clr | h_d_st | h_pad_st | h_dw_en | h_dw_dis | h_dw_st | h_wp;

   wire         h_protected = h_own_en | h_own_dis | h_oe_set | h_oe_clr | h_f_en | h_f_dis;

   wire         cfg_ok = wr_fire & ~wp_r;

   wire [31:0]  own_set = strobe(cfg_ok & h_own_en, pwdata);
   wire [31:0]  own_clr = strobe(cfg_ok & h_own_dis, pwdata);
   wire [31:0]  oe_set = strobe(cfg_ok & h_oe_set, pwdata);
   wire [31:0]  oe_clr = strobe(cfg_ok & h_oe_clr, pwdata);
   wire [31:0]  f_set = strobe(cfg_ok & h_f_en, pwdata);
   wire [31:0]  f_clr = strobe(cfg_ok & h_f_dis, pwdata);
   wire [31:0]  d_set = strobe(wr_fire & h_d_set, pwdata);
   wire [31:0]  d_clr = strobe(wr_fire & h_d_clr, pwdata);
   wire [31:0]  d_load = strobe(wr_fire & h_d_st, dw_q);
   wire [31:0]  dw_set = strobe(wr_fire & h_dw_en, pwdata);
   wire [31:0]  dw_clr = strobe(wr_fire & h_dw_dis, pwdata);
   wire         wp_nxt = (wr_fire & h_wp) ? pwdata[io_line_pkg::WRITE_PROTECT_BIT] : wp_r;

   wire [31:0]  line_value = (filt_q & clean_q) | (~filt_q & pad_in);
   wire [31:0]  pad_level_nxt = pad_sample_enable ? line_value : pad_level_r;

   wire [31:0]  pad_out_nxt = (owner_q & drive_q) | (~owner_q & periph_out);
   wire [31:0]  pad_oe_nxt  = (owner_q & oe_q) | (~owner_q & periph_oe);

   wire [31:0]  rd_val = h_own_st ? owner_q :
                         h_oe_st  ? oe_q :
                         h_f_st   ? filt_q :
                         h_d_st   ? drive_q :
                         h_pad_st ? pad_level_r :
                         h_dw_st  ? dw_q :
                         h_wp     ? {31'h0, wp_r} :
                         32'h00000000;

   setclr_bits #(.RESET_VAL(io_line_pkg::LINE_OWNER_RST)) u_owner
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_mask  (own_set),
      .clr_mask  (own_clr),
      .load_mask (32'h00000000),
      .load_data (32'h00000000),
      .bits_q    (owner_q)
   );

   setclr_bits #(.RESET_VAL(io_line_pkg::OUT_EN_RST)) u_oe
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_mask  (oe_set),
      .clr_mask  (oe_clr),
      .load_mask (32'h00000000),
      .load_data (32'h00000000),
      .bits_q    (oe_q)
   );

   setclr_bits #(.RESET_VAL(io_line_pkg::FILT_RST)) u_filt
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_mask  (f_set),
      .clr_mask  (f_clr),
      .load_mask (32'h00000000),
      .load_data (32'h00000000),
      .bits_q    (filt_q)
   );

   setclr_bits #(.RESET_VAL(io_line_pkg::DRIVE_RST)) u_drive
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_mask  (d_set),
      .clr_mask  (d_clr),
      .load_mask (d_load),
      .load_data (pwdata),
      .bits_q    (drive_q)
   );

   setclr_bits #(.RESET_VAL(io_line_pkg::DIRECT_WR_RST)) u_direct
   (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_mask  (dw_set),
      .clr_mask  (dw_clr),
      .load_mask (32'h00000000),
      .load_data (32'h00000000),
      .bits_q    (dw_q)
   );

   glitch_filter u_filter
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .raw_in  (pad_in),
      .clean_q (clean_q)
   );

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
      else
      begin
         pready_r  <= setup_ph;
         pslverr_r <= setup_ph & ~mapped;
         prdata_r  <= setup_ph ? rd_val : prdata_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r        <= io_line_pkg::WRITE_PROTECT_RST;
         pad_level_r <= io_line_pkg::PAD_RST;
         pad_out_r   <= 32'h00000000;
         pad_oe_r    <= 32'h00000000;
         periph_in_r <= 32'h00000000;
      end
      else
      begin
         wp_r        <= wp_nxt;
         pad_level_r <= pad_level_nxt;
         pad_out_r   <= pad_out_nxt;
         pad_oe_r    <= pad_oe_nxt;
         periph_in_r <= line_value;
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign pad_out   = pad_out_r;
   assign pad_oe    = pad_oe_r;
   assign periph_in = periph_in_r;

   property p_owner_set;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && h_own_en && !wp_r) |=> ((owner_q & $past(pwdata)) == $past(pwdata));
   endproperty
   a_owner_set: assert property (p_owner_set) else $error("Ownership enable did not set lines.");

   property p_owner_keep;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && h_own_en && !wp_r) |=> ((owner_q & ~$past(pwdata)) == ($past(owner_q) & ~$past(pwdata)));
   endproperty
   a_owner_keep: assert property (p_owner_keep) else $error("Ownership enable changed zero bits.");

   property p_owner_clr;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && h_own_dis && !wp_r) |=> ((owner_q & $past(pwdata)) == 32'h00000000);
   endproperty
   a_owner_clr: assert property (p_owner_clr) else $error("Ownership disable did not clear lines.");

   property p_protect;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && wp_r && h_protected) |=> ($stable(owner_q) && $stable(oe_q) && $stable(filt_q));
   endproperty
   a_protect: assert property (p_protect) else $error("Protected write changed a setting.");

   property p_oe_on_off;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && !wp_r && (h_oe_set || h_oe_clr)) |=>
         ((oe_q & $past(pwdata)) == ($past(h_oe_set) ? $past(pwdata) : 32'h00000000));
   endproperty
   a_oe_on_off: assert property (p_oe_on_off) else $error("Output enable set or clear failed.");

   property p_filt_on_off;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && !wp_r && (h_f_en || h_f_dis)) |=>
         ((filt_q & $past(pwdata)) == ($past(h_f_en) ? $past(pwdata) : 32'h00000000));
   endproperty
   a_filt_on_off: assert property (p_filt_on_off) else $error("Filter enable or disable failed.");

   property p_drive_set_clr;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && (h_d_set || h_d_clr)) |=>
         ((drive_q & $past(pwdata)) == ($past(h_d_set) ? $past(pwdata) : 32'h00000000));
   endproperty
   a_drive_set_clr: assert property (p_drive_set_clr) else $error("Drive level set or clear failed.");

   property p_direct_write;
      @(posedge sys_clk) disable iff (rst)
      (wr_fire && h_d_st) |=>
         (drive_q == (($past(pwdata) & $past(dw_q)) | ($past(drive_q) & ~$past(dw_q))));
   endproperty
   a_direct_write: assert property (p_direct_write) else $error("Direct drive write not masked.");

   property p_read_owner;
      @(posedge sys_clk) disable iff (rst)
      (setup_ph && !pwrite && h_own_st) |=> (pready_r && !pslverr_r && prdata_r == $past(owner_q));
   endproperty
   a_read_owner: assert property (p_read_owner) else $error("Ownership status read wrong.");

   property p_pad_hold;
      @(posedge sys_clk) disable iff (rst)
      (!pad_sample_enable) [*2] |=> $stable(pad_level_r);
   endproperty
   a_pad_hold: assert property (p_pad_hold) else $error("Pad levels moved with clock off.");

   property p_pad_follow;
      @(posedge sys_clk) disable iff (rst)
      (!rst && pad_sample_enable && $stable(pad_in) && (filt_q == 32'h00000000)) |=> (pad_level_r == $past(pad_in));
   endproperty
   a_pad_follow: assert property (p_pad_follow) else $error("Pad status missed line level.");

   property p_pad_drive;
      @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (pad_oe == (($past(owner_q) & $past(oe_q)) | (~$past(owner_q) & $past(periph_oe))));
   endproperty
   a_pad_drive: assert property (p_pad_drive) else $error("Pad driver enable mux wrong.");

   property p_pad_level_out;
      @(posedge sys_clk) disable iff (rst)
      !rst |=> (pad_out == (($past(owner_q) & $past(drive_q)) | (~$past(owner_q) & $past(periph_out))));
   endproperty
   a_pad_level_out: assert property (p_pad_level_out) else $error("Pad drive level mux wrong.");

   property p_read_filter;
      @(posedge sys_clk) disable iff (rst)
      (setup_ph && !pwrite && h_f_st) |=> (pready_r && prdata_r == $past(filt_q));
   endproperty
   a_read_filter: assert property (p_read_filter) else $error("Filter status read wrong.");

   c_owner_write: cover property (@(posedge sys_clk) disable iff (rst) wr_fire && h_own_en && !wp_r);
   c_protected_write: cover property (@(posedge sys_clk) disable iff (rst) wr_fire && wp_r && h_protected);
   c_direct_write: cover property (@(posedge sys_clk) disable iff (rst) wr_fire && h_d_st && (dw_q != 32'h00000000));
   c_unmapped: cover property (@(posedge sys_clk) disable iff (rst) pready_r && pslverr_r);

endmodule

// ---- sim/pad_model.sv ----
// Purpose: Far side of the I/O lines: pads with an outside level and a peripheral.
// Assumes: Pads settle at once; a line with its driver off takes the outside level.
// Notes: Peripheral drive values are fixed parameters.
`timescale 1ns/1ns
module pad_model
#(
   parameter logic [31:0] PERIPH_OUT = 32'h0f0f3c3c,
   parameter logic [31:0] PERIPH_OE  = 32'h00ff00ff
)
(
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] ext_level,
   output logic      [31:0] pad_in,
   output logic      [31:0] periph_out,
   output logic      [31:0] periph_oe
);
   // A driven line shows its drive level, an undriven one the outside level.
   assign pad_in     = (pad_oe & pad_out) | (~pad_oe & ext_level);
   assign periph_out = PERIPH_OUT;
   assign periph_oe  = PERIPH_OE;
endmodule

// ---- sim/testbench.sv ----
// Purpose: Register and pad level test of the I/O line control block.
// Assumes: APB slave answers after one access cycle; pad model on the far side.
// Notes: Expected values are kept in bench variables and updated per write.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s exp=%h got=%h", nm, e, g); end end
module testbench;
   localparam logic [31:0] PO  = 32'h0f0f3c3c;
   localparam logic [31:0] POE = 32'h00ff00ff;
   logic        sys_clk, rst, psel, penable, pwrite, pse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pad_out, pad_oe, pad_in, p_out, p_oe, ext, p_in;
   logic        pready, pslverr, err;
   logic [31:0] own, oe, flt, drv, rd;
   int          n_fail, n_checks;

   pin_io_line_control pin_io_line_control_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_sample_enable(pse), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in));
   pad_model #(.PERIPH_OUT(PO), .PERIPH_OE(POE)) pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe),
      .ext_level(ext), .pad_in(pad_in), .periph_out(p_out), .periph_oe(p_oe));

   always #5 sys_clk = ~sys_clk;

   task final_report();
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && k < 50)
      begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 50)
      begin
         n_fail++;
         final_report();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      `CHK("read data", e, rd)
      `CHK("read error", 1'b0, err)
   endtask

   function logic [31:0] exp_oe();
      return (own & oe) | (~own & POE);
   endfunction

   function logic [31:0] exp_out();
      return (own & drv) | (~own & PO);
   endfunction

   function logic [31:0] exp_pad();
      return (exp_oe() & exp_out()) | (~exp_oe() & ext);
   endfunction

   initial
   begin
      sys_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; pse = 1'b1;
      paddr = 12'h000; pwdata = 32'h00000000; ext = 32'h5a5ac3c3; n_fail = 0; n_checks = 0;
      own = 32'hffffffff; oe = 32'h00000000; flt = 32'h00000000; drv = 32'h00000000;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(io_line_pkg::LINE_OWNER_STAT_OFF, own);
      rchk(io_line_pkg::OUT_EN_STAT_OFF, oe);
      rchk(io_line_pkg::FILT_STAT_OFF, flt);
      rchk(io_line_pkg::OUT_EN_SET_OFF, 32'h00000000);
      wr(io_line_pkg::LINE_OWNER_DIS_OFF, 32'h0000ffff);
      wr(io_line_pkg::LINE_OWNER_EN_OFF, 32'h00000003);
      own = 32'hffff0003;
      rchk(io_line_pkg::LINE_OWNER_STAT_OFF, own);
      wr(io_line_pkg::OUT_EN_SET_OFF, 32'ha5a5a5a5);
      wr(io_line_pkg::OUT_EN_CLR_OFF, 32'h0000ffff);
      oe = 32'ha5a50000;
      rchk(io_line_pkg::OUT_EN_STAT_OFF, oe);
      wr(io_line_pkg::FILT_EN_OFF, 32'h0000ff00);
      wr(io_line_pkg::FILT_DIS_OFF, 32'h0000f000);
      flt = 32'h00000f00;
      rchk(io_line_pkg::FILT_STAT_OFF, flt);
      wr(io_line_pkg::DRIVE_SET_OFF, 32'hf0f0f0f0);
      wr(io_line_pkg::DRIVE_CLR_OFF, 32'h00ff00ff);
      drv = 32'hf000f000;
      rchk(io_line_pkg::DRIVE_STAT_OFF, drv);
      wr(io_line_pkg::DRIVE_STAT_OFF, 32'h12345678);
      rchk(io_line_pkg::DRIVE_STAT_OFF, drv);
      wr(io_line_pkg::DIRECT_WR_EN_OFF, 32'h000000ff);
      rchk(io_line_pkg::DIRECT_WR_STAT_OFF, 32'h000000ff);
      wr(io_line_pkg::DRIVE_STAT_OFF, 32'h12345678);
      drv = 32'hf000f078;
      rchk(io_line_pkg::DRIVE_STAT_OFF, drv);
      wr(io_line_pkg::DIRECT_WR_DIS_OFF, 32'h000000f0);
      rchk(io_line_pkg::DIRECT_WR_STAT_OFF, 32'h0000000f);
      wr(io_line_pkg::DRIVE_STAT_OFF, 32'h00000000);
      drv = 32'hf000f070;
      rchk(io_line_pkg::DRIVE_STAT_OFF, drv);
      wr(io_line_pkg::WRITE_PROTECT_OFF, 32'h00000001);
      rchk(io_line_pkg::WRITE_PROTECT_OFF, 32'h00000001);
      wr(io_line_pkg::LINE_OWNER_DIS_OFF, 32'hffffffff);
      wr(io_line_pkg::OUT_EN_SET_OFF, 32'hffffffff);
      wr(io_line_pkg::FILT_EN_OFF, 32'hffffffff);
      wr(io_line_pkg::FILT_DIS_OFF, 32'hffffffff);
      rchk(io_line_pkg::LINE_OWNER_STAT_OFF, own);
      rchk(io_line_pkg::OUT_EN_STAT_OFF, oe);
      rchk(io_line_pkg::FILT_STAT_OFF, flt);
      wr(io_line_pkg::WRITE_PROTECT_OFF, 32'h00000000);
      wr(io_line_pkg::OUT_EN_CLR_OFF, 32'h00010000);
      oe = 32'ha5a40000;
      rchk(io_line_pkg::OUT_EN_STAT_OFF, oe);
      repeat (4) @(posedge sys_clk);
      `CHK("pad_oe", exp_oe(), pad_oe)
      `CHK("pad_out", exp_out(), pad_out)
      `CHK("periph_in", exp_pad(), p_in)
      rchk(io_line_pkg::PAD_STAT_OFF, exp_pad());
      rd = exp_pad();
      pse <= 1'b0;
      repeat (2) @(posedge sys_clk);
      ext <= ~ext;
      repeat (4) @(posedge sys_clk);
      rchk(io_line_pkg::PAD_STAT_OFF, rd);
      pse <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rchk(io_line_pkg::PAD_STAT_OFF, exp_pad());
      apb(1'b1, 12'h100, 32'hffffffff);
      `CHK("unmapped error", 1'b1, err)
      final_report();
   end
endmodule
